// ==== hdl/nco_pkg.sv ====
// Purpose: Shared constants for the oscillator phase/frequency control front end.
// Assumes: One system clock; host control words arrive on an asynchronous strobe.
// Notes: Status readback is over APB; control words are written on the strobe port.
package nco_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CTRL_W = 16;
  localparam int SEL_W = 2;
  localparam int QUAD_W = 2;
  localparam int PHASE_LOW_W = 14;
  localparam int ACC_W_DEF = 32;
  localparam int SAMPLE_W_DEF = 19;
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;

  // ----------------------------------------------------------------
  // Host register-select codes
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_PHASE = 2'h0;
  localparam logic [SEL_W-1:0] SEL_CENTER = 2'h1;
  localparam logic [SEL_W-1:0] SEL_OFFSET = 2'h2;
  localparam logic [SEL_W-1:0] SEL_TIME = 2'h3;

  // ----------------------------------------------------------------
  // APB readback map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [APB_ADDR_W-1:0] ADDR_PHASE_CTRL = 8'h00;
  localparam logic [APB_ADDR_W-1:0] ADDR_CENTER_CTRL = 8'h04;
  localparam logic [APB_ADDR_W-1:0] ADDR_OFFSET_CTRL = 8'h08;
  localparam logic [APB_ADDR_W-1:0] ADDR_TIME_CTRL = 8'h0c;
  localparam logic [APB_ADDR_W-1:0] ADDR_PHASE_ACC = 8'h10;
  localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = 8'h14;

  // Status word bit positions
  localparam int STAT_WRAP_BIT = 0;
  localparam int STAT_TIMER_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic ENABLE_N_IDLE = 1'b1;
  localparam logic LEVEL_IDLE = 1'b0;

endpackage : nco_pkg

// ==== hdl/nco_ctrl_if.sv ====
// Purpose: Carries the host-written control words to the oscillator core.
// Assumes: Driven and read on pclk only.
// Notes: One writer (host port), one reader (core).
`timescale 1ns/1ps
interface nco_ctrl_if;
  logic [nco_pkg::CTRL_W-1:0] phase_ctrl;
  logic [nco_pkg::CTRL_W-1:0] center_ctrl;
  logic [nco_pkg::CTRL_W-1:0] offset_ctrl;
  logic [nco_pkg::CTRL_W-1:0] time_ctrl;

  modport port (output phase_ctrl, output center_ctrl, output offset_ctrl, output time_ctrl);
  modport core (input phase_ctrl, input center_ctrl, input offset_ctrl, input time_ctrl);
endinterface : nco_ctrl_if

// ==== hdl/nco_host_port.sv ====
// Purpose: Host control-word write port with strobe-edge capture.
// Assumes: Host holds data, select and chip select steady around the strobe rise.
// Notes: The strobe is asynchronous, so every pin is brought in through two flops, the strobe through three.
`timescale 1ns/1ps
module nco_host_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host pins
  input wire logic [nco_pkg::CTRL_W-1:0] control_word_bus,
  input wire logic [nco_pkg::SEL_W-1:0] register_select,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  // Control words out
  nco_ctrl_if.port ctrl
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [nco_pkg::CTRL_W-1:0] data_s1, data_s2;
  logic [nco_pkg::SEL_W-1:0] sel_s1, sel_s2;
  logic cs_s1, cs_s2;
  logic wr_s1, wr_s2, wr_s3;
  logic write_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_s1 <= nco_pkg::CTRL_RESET;
      data_s2 <= nco_pkg::CTRL_RESET;
      sel_s1 <= nco_pkg::SEL_PHASE;
      sel_s2 <= nco_pkg::SEL_PHASE;
      cs_s1 <= nco_pkg::ENABLE_N_IDLE;
      cs_s2 <= nco_pkg::ENABLE_N_IDLE;
      wr_s1 <= nco_pkg::ENABLE_N_IDLE;
      wr_s2 <= nco_pkg::ENABLE_N_IDLE;
      wr_s3 <= nco_pkg::ENABLE_N_IDLE;
    end else begin
      data_s1 <= control_word_bus;
      data_s2 <= data_s1;
      sel_s1 <= register_select;
      sel_s2 <= sel_s1;
      cs_s1 <= chip_select_n;
      cs_s2 <= cs_s1;
      wr_s1 <= write_strobe_n;
      wr_s2 <= wr_s1;
      wr_s3 <= wr_s2;
    end
  end

  // Rising strobe edge while chip select is low
  assign write_hit = wr_s2 && !wr_s3 && !cs_s2;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.phase_ctrl <= nco_pkg::CTRL_RESET;
      ctrl.center_ctrl <= nco_pkg::CTRL_RESET;
      ctrl.offset_ctrl <= nco_pkg::CTRL_RESET;
      ctrl.time_ctrl <= nco_pkg::CTRL_RESET;
    end else if (write_hit) begin
      case (sel_s2)
        nco_pkg::SEL_PHASE: ctrl.phase_ctrl <= data_s2;
        nco_pkg::SEL_CENTER: ctrl.center_ctrl <= data_s2;
        nco_pkg::SEL_OFFSET: ctrl.offset_ctrl <= data_s2;
        nco_pkg::SEL_TIME: ctrl.time_ctrl <= data_s2;
        default: ctrl.phase_ctrl <= ctrl.phase_ctrl;
      endcase
    end
  end

endmodule : nco_host_port

// ==== hdl/nco_phase_frequency_control.sv ====
// Purpose: Phase/frequency control section of a numerically controlled oscillator.
// Assumes: Timing pins are driven by logic on pclk; host strobe port is asynchronous.
// Notes: Sine/cosine tables sit outside; this block addresses them and feeds the multiplier.
//
// Operation
// - Control words are 16 bits wide, bit 15 most significant.
// - Control word captured on write strobe rising edge while chip select low.
// - All other registers update on pclk rising edge; those with a load enable only while it is low.
// - Registered low phase load enable lets the phase register load.
// - Registered low offset load enable lets the offset register load.
// - Registered low center load enable lets the center register load.
// - Registered low accumulator enable lets the phase accumulator update.
// - Registered low time load enable lets the time accumulator load.
// - Registered low sample enable loads real and imaginary input registers.
// - Registered half-circle select high forces the top table address bit low.
// - Registered low offset-zero zeros offset path, register itself unaffected.
// - Registered low reload zeros accumulator feedback, register not cleared.
// - Quadrant inputs add 0/90/180/270 degrees with low 14 bits zero.
// - Quadrant inputs enter the phase register only while its enable is low.
// - Phase source high takes host phase word, low takes quadrant bits.
// - Registered low bypass sends phase sum and accumulator bits past tables.
// - Registered low wrap output marks phase accumulator overflow.
// - Low carry input adds one to the phase accumulator step.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module nco_phase_frequency_control #(
  parameter int ACC_W = nco_pkg::ACC_W_DEF,
  parameter int SAMPLE_W = nco_pkg::SAMPLE_W_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host control-word port
  input wire logic [nco_pkg::CTRL_W-1:0] control_word_bus,
  input wire logic [nco_pkg::SEL_W-1:0] register_select,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  // Timing controls
  input wire logic phase_reg_load_en_n,
  input wire logic freq_offset_load_en_n,
  input wire logic center_freq_load_en_n,
  input wire logic phase_acc_update_en_n,
  input wire logic time_interval_load_en_n,
  input wire logic input_sample_en_n,
  input wire logic half_circle_select,
  input wire logic offset_path_zero_n,
  input wire logic acc_reload_n,
  input wire logic [nco_pkg::QUAD_W-1:0] quadrant_offset,
  input wire logic phase_source_select,
  input wire logic table_bypass_timer_reload_n,
  input wire logic phase_carry_in_n,
  // Input samples
  input wire logic [SAMPLE_W-1:0] real_sample_in,
  input wire logic [SAMPLE_W-1:0] imag_sample_in,
  // Sine/cosine tables
  input wire logic [nco_pkg::CTRL_W-1:0] sine_table_data,
  input wire logic [nco_pkg::CTRL_W-1:0] cosine_table_data,
  output logic [nco_pkg::CTRL_W-1:0] table_address,
  // Multiplier feed
  output logic [nco_pkg::CTRL_W-1:0] mult_sine,
  output logic [nco_pkg::CTRL_W-1:0] mult_cosine,
  output logic [SAMPLE_W-1:0] real_input_register,
  output logic [SAMPLE_W-1:0] imag_input_register,
  // Events
  output logic phase_wrap_out_n,
  output logic timer_carry_out_n,
  // APB readback
  input wire logic [nco_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [nco_pkg::APB_DATA_W-1:0] pwdata,
  output logic [nco_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Host port
  // ----------------------------------------------------------------
  nco_ctrl_if ctrl ();

  nco_host_port u_host_port (
    .pclk(pclk),
    .presetn(presetn),
    .control_word_bus(control_word_bus),
    .register_select(register_select),
    .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n),
    .ctrl(ctrl.port)
  );

  // ----------------------------------------------------------------
  // Registered timing controls
  // ----------------------------------------------------------------
  logic phase_en_n_q, offset_en_n_q, center_en_n_q, acc_en_n_q;
  logic time_en_n_q, sample_en_n_q, offset_zero_n_q, reload_n_q;
  logic bypass_n_q, carry_in_n_q, half_circle_q, phase_source_q;
  logic [nco_pkg::QUAD_W-1:0] quadrant_q;

  // One stage only: these pins come from logic on the same clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_en_n_q <= nco_pkg::ENABLE_N_IDLE;
      offset_en_n_q <= nco_pkg::ENABLE_N_IDLE;
      center_en_n_q <= nco_pkg::ENABLE_N_IDLE;
      acc_en_n_q <= nco_pkg::ENABLE_N_IDLE;
      time_en_n_q <= nco_pkg::ENABLE_N_IDLE;
      sample_en_n_q <= nco_pkg::ENABLE_N_IDLE;
      offset_zero_n_q <= nco_pkg::ENABLE_N_IDLE;
      reload_n_q <= nco_pkg::ENABLE_N_IDLE;
      bypass_n_q <= nco_pkg::ENABLE_N_IDLE;
      carry_in_n_q <= nco_pkg::ENABLE_N_IDLE;
      half_circle_q <= nco_pkg::LEVEL_IDLE;
      phase_source_q <= nco_pkg::LEVEL_IDLE;
      quadrant_q <= '0;
    end else begin
      phase_en_n_q <= phase_reg_load_en_n;
      offset_en_n_q <= freq_offset_load_en_n;
      center_en_n_q <= center_freq_load_en_n;
      acc_en_n_q <= phase_acc_update_en_n;
      time_en_n_q <= time_interval_load_en_n;
      sample_en_n_q <= input_sample_en_n;
      offset_zero_n_q <= offset_path_zero_n;
      reload_n_q <= acc_reload_n;
      bypass_n_q <= table_bypass_timer_reload_n;
      carry_in_n_q <= phase_carry_in_n;
      half_circle_q <= half_circle_select;
      phase_source_q <= phase_source_select;
      quadrant_q <= quadrant_offset;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator step, shared by phase and time accumulators
  // ----------------------------------------------------------------
  function automatic logic [ACC_W:0] acc_step(input logic [ACC_W-1:0] fb,
                                              input logic [ACC_W-1:0] inc,
                                              input logic zero_fb,
                                              input logic cin);
    logic [ACC_W-1:0] base;
    base = zero_fb ? '0 : fb;
    return {1'b0, base} + {1'b0, inc} + {{ACC_W{1'b0}}, cin};
  endfunction : acc_step

  // ----------------------------------------------------------------
  // Phase and frequency registers
  // ----------------------------------------------------------------
  logic [nco_pkg::CTRL_W-1:0] phase_reg, offset_reg, center_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= nco_pkg::CTRL_RESET;
    end else if (!phase_en_n_q) begin
      if (phase_source_q) begin
        phase_reg <= ctrl.phase_ctrl;
      end else begin
        phase_reg <= {quadrant_q, {nco_pkg::PHASE_LOW_W{1'b0}}};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_reg <= nco_pkg::CTRL_RESET;
    end else if (!offset_en_n_q) begin
      offset_reg <= ctrl.offset_ctrl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      center_reg <= nco_pkg::CTRL_RESET;
    end else if (!center_en_n_q) begin
      center_reg <= ctrl.center_ctrl;
    end
  end

  // Zeroing acts on the path only, so the offset stays loadable meanwhile
  logic [nco_pkg::CTRL_W-1:0] offset_path;
  logic [nco_pkg::CTRL_W:0] freq_sum;
  logic [ACC_W-1:0] freq_inc;

  assign offset_path = offset_zero_n_q ? offset_reg : '0;
  assign freq_sum = {1'b0, center_reg} + {1'b0, offset_path};
  assign freq_inc = ACC_W'(freq_sum);

  // ----------------------------------------------------------------
  // Phase accumulator and wrap flag
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] phase_acc;
  logic [ACC_W:0] next_phase_acc;

  assign next_phase_acc = acc_step(phase_acc, freq_inc, !reload_n_q, !carry_in_n_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_acc <= '0;
    end else if (!acc_en_n_q) begin
      phase_acc <= next_phase_acc[ACC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_wrap_out_n <= nco_pkg::ENABLE_N_IDLE;
    end else begin
      phase_wrap_out_n <= !(!acc_en_n_q && next_phase_acc[ACC_W]);
    end
  end

  // ----------------------------------------------------------------
  // Phase adder, table addressing and multiplier feed
  // ----------------------------------------------------------------
  logic [nco_pkg::CTRL_W-1:0] phase_sum;

  assign phase_sum = phase_acc[ACC_W-1 -: nco_pkg::CTRL_W] + phase_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_address <= '0;
    end else if (half_circle_q) begin
      table_address <= {1'b0, phase_sum[nco_pkg::CTRL_W-2:0]};
    end else begin
      table_address <= phase_sum;
    end
  end

  // Table data is one table latency behind the bypass path; users switching
  // bypass on the fly see that skew for a cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_sine <= '0;
      mult_cosine <= '0;
    end else if (!bypass_n_q) begin
      mult_sine <= phase_sum;
      mult_cosine <= phase_acc[nco_pkg::CTRL_W-1:0];
    end else begin
      mult_sine <= sine_table_data;
      mult_cosine <= cosine_table_data;
    end
  end

  // ----------------------------------------------------------------
  // Time interval accumulator
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] time_acc;
  logic [ACC_W:0] next_time_acc;

  assign next_time_acc = acc_step(time_acc, ACC_W'(ctrl.time_ctrl), !bypass_n_q, 1'b0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_acc <= '0;
    end else if (!time_en_n_q) begin
      time_acc <= next_time_acc[ACC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_carry_out_n <= nco_pkg::ENABLE_N_IDLE;
    end else begin
      timer_carry_out_n <= !(!time_en_n_q && next_time_acc[ACC_W]);
    end
  end

  // ----------------------------------------------------------------
  // Input sample registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      real_input_register <= '0;
      imag_input_register <= '0;
    end else if (!sample_en_n_q) begin
      real_input_register <= real_sample_in;
      imag_input_register <= imag_sample_in;
    end
  end

  // ----------------------------------------------------------------
  // APB readback slave
  // ----------------------------------------------------------------
  // Writes are refused: the control words belong to the strobe port, and
  // a second writer would race it.
  logic [nco_pkg::APB_DATA_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[nco_pkg::STAT_WRAP_BIT] = phase_wrap_out_n;
    status_word[nco_pkg::STAT_TIMER_BIT] = timer_carry_out_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= pwrite;
      prdata <= '0;
      if (!pwrite) begin
        case (paddr)
          nco_pkg::ADDR_PHASE_CTRL: prdata <= 32'(ctrl.phase_ctrl);
          nco_pkg::ADDR_CENTER_CTRL: prdata <= 32'(ctrl.center_ctrl);
          nco_pkg::ADDR_OFFSET_CTRL: prdata <= 32'(ctrl.offset_ctrl);
          nco_pkg::ADDR_TIME_CTRL: prdata <= 32'(ctrl.time_ctrl);
          nco_pkg::ADDR_PHASE_ACC: prdata <= 32'(phase_acc);
          nco_pkg::ADDR_STATUS: prdata <= status_word;
          default: pslverr <= 1'b1;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : nco_phase_frequency_control

// ==== verification/nco_pfc_assertions.sv ====
// Purpose: Port-level checks.
// Assumes: One pclk domain.
// Notes: Pin effects show two edges after sampling.
`timescale 1ns/1ps
module nco_pfc_assertions #(
  parameter int SAMPLE_W = nco_pkg::SAMPLE_W_DEF
) (
  input logic pclk,
  input logic presetn,
  input logic phase_acc_update_en_n,
  input logic input_sample_en_n,
  input logic half_circle_select,
  input logic [SAMPLE_W-1:0] real_sample_in,
  input logic [SAMPLE_W-1:0] imag_sample_in,
  input logic [nco_pkg::CTRL_W-1:0] table_address,
  input logic [SAMPLE_W-1:0] real_input_register,
  input logic [SAMPLE_W-1:0] imag_input_register,
  input logic phase_wrap_out_n,
  input logic [nco_pkg::APB_ADDR_W-1:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [nco_pkg::APB_DATA_W-1:0] prdata,
  input logic pready,
  input logic pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_pending;
    psel && penable && !pready;
  endsequence
  sequence apb_done;
    psel && penable && pready;
  endsequence

  a_apb_one_wait: assert property (apb_pending |=> pready)
    else $error("late pready");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready too long");
  a_write_refused: assert property (apb_done ##0 pwrite |-> pslverr)
    else $error("write not refused");
  a_unmapped_read: assert property (apb_done ##0 (!pwrite && paddr > 8'h14)
    |-> pslverr && prdata == 32'h0) else $error("bad read accepted");
  a_mapped_read: assert property (apb_done ##0 (!pwrite && paddr[1:0] == 2'h0
    && paddr <= 8'h14) |-> !pslverr) else $error("mapped read refused");
  a_wrap_cause: assert property ($fell(phase_wrap_out_n) |-> !$past(phase_acc_update_en_n, 2))
    else $error("wrap without update");
  a_wrap_single: assert property (!phase_wrap_out_n |=> phase_wrap_out_n)
    else $error("long wrap");
  a_half_circle: assert property ($past(half_circle_select, 2) |-> !table_address[15])
    else $error("table bit 15 set");
  a_sample_load: assert property (!$past(input_sample_en_n, 2) |->
    real_input_register == $past(real_sample_in) && imag_input_register == $past(imag_sample_in))
    else $error("samples not loaded");
  a_sample_hold: assert property ($past(input_sample_en_n, 2) |-> $stable(real_input_register))
    else $error("sample reg changed");
endmodule : nco_pfc_assertions

// ==== verification/nco_host_model.sv ====
// Purpose: Host writing control words.
// Assumes: Bus steady at least 4 pclk around strobe rise.
// Notes: Released bus shows the inverse value.
`timescale 1ns/1ps
module nco_host_model (
  // Clock
  input wire logic pclk,
  // Host pins
  output logic [nco_pkg::CTRL_W-1:0] control_word_bus = 16'h0000,
  output logic [nco_pkg::SEL_W-1:0] register_select = 2'h0,
  output logic chip_select_n = 1'b1,
  output logic write_strobe_n = 1'b1
);
  task automatic write_word(input logic [1:0] sel, input logic [15:0] word, input logic cs_n);
    @(posedge pclk);
    control_word_bus <= word;
    register_select <= sel;
    chip_select_n <= cs_n;
    repeat (3) @(posedge pclk);
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge pclk);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chip_select_n <= 1'b1;
    control_word_bus <= ~word;
    register_select <= ~sel;
    repeat (3) @(posedge pclk);
  endtask : write_word
endmodule : nco_host_model

// ==== verification/nco_phase_frequency_control_tb.sv ====
// Purpose: Self-checking bench.
// Assumes: Constant table data.
// Notes: Each enable pulse gives one update.
`timescale 1ns/1ps
module nco_phase_frequency_control_tb;
  localparam int SW = nco_pkg::SAMPLE_W_DEF;
  // Enable vector bits: phase, offset, center, acc, time, sample, reload, carry
  localparam logic [7:0] PH = 8'h01, OF = 8'h02, CF = 8'h04, AC = 8'h08;
  localparam logic [7:0] SM = 8'h20, RL = 8'h40, CI = 8'h80;
  logic pclk = 1'b0, presetn = 1'b0;
  logic [7:0] en_n = 8'hff;
  logic half_circle_select = 1'b0, offset_path_zero_n = 1'b1, phase_source_select = 1'b1;
  logic table_bypass_timer_reload_n = 1'b1;
  logic [1:0] quadrant_offset = 2'h0;
  logic [SW-1:0] real_sample_in = '0, imag_sample_in = '0;
  logic [15:0] sine_table_data = 16'h5a5a, cosine_table_data = 16'ha5a5;
  logic [15:0] control_word_bus, table_address, mult_sine, mult_cosine;
  logic [1:0] register_select;
  logic chip_select_n, write_strobe_n, phase_wrap_out_n, timer_carry_out_n;
  logic [SW-1:0] real_input_register, imag_input_register;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] pwdata = 32'h0, prdata;
  int miscompares = 0, tests_run = 0;

  always #2 pclk = ~pclk;

  nco_host_model HOST (.pclk(pclk), .control_word_bus(control_word_bus),
    .register_select(register_select), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n));

  nco_phase_frequency_control #(.SAMPLE_W(SW)) DUT (.pclk(pclk), .presetn(presetn),
    .control_word_bus(control_word_bus), .register_select(register_select),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .phase_reg_load_en_n(en_n[0]), .freq_offset_load_en_n(en_n[1]),
    .center_freq_load_en_n(en_n[2]), .phase_acc_update_en_n(en_n[3]),
    .time_interval_load_en_n(en_n[4]), .input_sample_en_n(en_n[5]),
    .half_circle_select(half_circle_select), .offset_path_zero_n(offset_path_zero_n),
    .acc_reload_n(en_n[6]), .quadrant_offset(quadrant_offset),
    .phase_source_select(phase_source_select),
    .table_bypass_timer_reload_n(table_bypass_timer_reload_n),
    .phase_carry_in_n(en_n[7]), .real_sample_in(real_sample_in),
    .imag_sample_in(imag_sample_in), .sine_table_data(sine_table_data),
    .cosine_table_data(cosine_table_data), .table_address(table_address),
    .mult_sine(mult_sine), .mult_cosine(mult_cosine),
    .real_input_register(real_input_register), .imag_input_register(imag_input_register),
    .phase_wrap_out_n(phase_wrap_out_n), .timer_carry_out_n(timer_carry_out_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic check(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] exp, input logic err);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= 32'hffff_ffff;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    check("pslverr", 32'(err), 32'(pslverr));
    if (!w) check("prdata", exp, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic acc_is(input logic [31:0] e);
    apb(nco_pkg::ADDR_PHASE_ACC, 1'b0, e, 1'b0);
  endtask : acc_is

  task automatic pulse(input logic [7:0] m);
    @(posedge pclk);
    en_n <= ~m;
    @(posedge pclk);
    en_n <= 8'hff;
    repeat (4) @(posedge pclk);
  endtask : pulse

  task automatic t_host;
    HOST.write_word(nco_pkg::SEL_PHASE, 16'h8001, 1'b0);
    HOST.write_word(nco_pkg::SEL_CENTER, 16'h0010, 1'b0);
    HOST.write_word(nco_pkg::SEL_OFFSET, 16'h0002, 1'b0);
    HOST.write_word(nco_pkg::SEL_TIME, 16'h1234, 1'b0);
    HOST.write_word(nco_pkg::SEL_CENTER, 16'hffff, 1'b1);
    apb(nco_pkg::ADDR_PHASE_CTRL, 1'b0, 32'h8001, 1'b0);
    apb(nco_pkg::ADDR_CENTER_CTRL, 1'b0, 32'h0010, 1'b0);
    apb(nco_pkg::ADDR_OFFSET_CTRL, 1'b0, 32'h0002, 1'b0);
    apb(nco_pkg::ADDR_TIME_CTRL, 1'b0, 32'h1234, 1'b0);
    apb(nco_pkg::ADDR_PHASE_CTRL, 1'b1, 32'h0, 1'b1);
    apb(nco_pkg::ADDR_PHASE_CTRL, 1'b0, 32'h8001, 1'b0);
    apb(8'h18, 1'b0, 32'h0, 1'b1);
    apb(nco_pkg::ADDR_STATUS, 1'b0, 32'h3, 1'b0);
    $display("test host_and_bus done");
  endtask : t_host

  task automatic t_acc;
    pulse(CF | OF);
    pulse(AC | RL);
    acc_is(32'h12);
    pulse(AC);
    acc_is(32'h24);
    pulse(RL);
    acc_is(32'h24);
    pulse(AC | RL | CI);
    acc_is(32'h13);
    offset_path_zero_n <= 1'b0;
    pulse(AC | RL);
    acc_is(32'h10);
    offset_path_zero_n <= 1'b1;
    pulse(AC | RL);
    acc_is(32'h12);
    $display("test accumulator done");
  endtask : t_acc

  task automatic t_phase;
    phase_source_select <= 1'b0;
    for (int q = 0; q < 4; q++) begin
      quadrant_offset <= q[1:0];
      pulse(PH);
      check("quadrant address", {16'h0, q[1:0], 14'h0}, {16'h0, table_address});
    end
    half_circle_select <= 1'b1;
    repeat (4) @(posedge pclk);
    check("half circle", 32'h4000, {16'h0, table_address});
    half_circle_select <= 1'b0;
    quadrant_offset <= 2'h0;
    repeat (4) @(posedge pclk);
    check("quadrant hold", 32'hc000, {16'h0, table_address});
    phase_source_select <= 1'b1;
    pulse(PH);
    check("host phase", 32'h8001, {16'h0, table_address});
    check("table sine", 32'h5a5a, {16'h0, mult_sine});
    table_bypass_timer_reload_n <= 1'b0;
    repeat (4) @(posedge pclk);
    check("bypass sine", 32'h8001, {16'h0, mult_sine});
    check("bypass cosine", 32'h0012, {16'h0, mult_cosine});
    table_bypass_timer_reload_n <= 1'b1;
    $display("test phase_path done");
  endtask : t_phase

  task automatic t_sample;
    real_sample_in <= 19'h41234;
    imag_sample_in <= 19'h70001;
    repeat (3) @(posedge pclk);
    check("real idle", 32'h0, {13'h0, real_input_register});
    pulse(SM);
    check("real load", 32'h41234, {13'h0, real_input_register});
    check("imag load", 32'h70001, {13'h0, imag_input_register});
    $display("test samples done");
  endtask : t_sample

  task automatic t_wrap;
    int n;
    HOST.write_word(nco_pkg::SEL_CENTER, 16'hffff, 1'b0);
    HOST.write_word(nco_pkg::SEL_OFFSET, 16'hffff, 1'b0);
    pulse(CF | OF);
    pulse(AC | RL);
    acc_is(32'h1fffe);
    @(posedge pclk);
    en_n <= ~AC;
    for (n = 0; phase_wrap_out_n !== 1'b0 && n < 40000; n++) @(posedge pclk);
    en_n <= 8'hff;
    check("wrap in window", 32'h1, {31'h0, n >= 32769 && n <= 32772});
    $display("test wrap done");
  endtask : t_wrap

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    miscompares++;
    final_report;
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_host;
    t_acc;
    t_phase;
    t_sample;
    t_wrap;
    final_report;
  end
endmodule : nco_phase_frequency_control_tb

bind nco_phase_frequency_control nco_pfc_assertions #(.SAMPLE_W(SAMPLE_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .phase_acc_update_en_n(phase_acc_update_en_n),
  .input_sample_en_n(input_sample_en_n), .half_circle_select(half_circle_select),
  .real_sample_in(real_sample_in), .imag_sample_in(imag_sample_in),
  .table_address(table_address), .real_input_register(real_input_register),
  .imag_input_register(imag_input_register), .phase_wrap_out_n(phase_wrap_out_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
